/* File: verilog/cic_top.sv */
// Core interrupt controller: flags, enables, vectoring, sleep wake, AXI4-Lite registers.
// Assumes the sequencer supplies Q phases on aclk and obeys the pulses it receives.
// Function
// - Twelve sources, each with flag and enable
// - Any reset leaves all interrupts disabled
// - Take needs global and own enable, plus peripheral enable for peripherals
// - Flags set regardless of any enable
// - Take: flush, clear global, push, vector
// - Global clear only records; serviced when set
// - Return pops address and sets global enable
// - Latency three, async three to four cycles
// - Latency same for one or two-cycle instructions
// - Pin flag sets Q4-Q1, sampled each Q1
// - Only clockless enabled sources wake from sleep
// - Next instruction runs before vectoring after wake
// - Pin is async edge, polarity selectable
// - Pin edge sets flag; redirect needs both enables
// - Only return address saved on entry
// - Vector load leaves high latch untouched
// - Control register fully readable and writable
// - Control bits: 7 global, 6 periph, 4 pin, 1 flag
`timescale 1ns/100ps
`include "cic_defines.svh"

module cic_top #(
  parameter logic [`CIC_NUM_SOURCES-1:0] WAKE_MASK = `CIC_WAKE_MASK
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`CIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`CIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cic_pkg::cic_events_t events,
  input wire logic ext_irq_pin,
  input wire cic_pkg::cic_seq_in_t seq_in,
  output cic_pkg::cic_seq_out_t seq_out
);
  import cic_pkg::*;

  logic [7:0] core_irq_control_reg;
  logic [7:0] peripheral_enables_1_reg;
  logic [7:0] peripheral_enables_2_reg;
  logic [7:0] peripheral_flags_1_reg;
  logic [7:0] peripheral_flags_2_reg;
  logic ext_edge_select_reg;
  cic_state_t state_reg;
  logic sleeping_reg;
  logic [1:0] wake_hold_reg;
  logic pin_edge_pend_reg;
  logic pending_sampled_reg;

  logic aw_held_reg;
  logic [`CIC_ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;

  logic ext_edge;
  logic is_q1;
  logic pin_flag_window;
  logic wr_fire;
  logic wr_ok;
  logic take;
  logic pending;
  logic [`CIC_NUM_SOURCES-1:0] src_flags;
  logic [`CIC_NUM_SOURCES-1:0] src_enables;
  logic [7:0] ctrl_next;
  logic [7:0] pflags1_next;
  logic [7:0] pflags2_next;

  // Hardware set beats a software clear in the same cycle
  function automatic logic [7:0] set_wins(input logic [7:0] cur, input logic wr,
                                         input logic [7:0] wdat, input logic [7:0] ev);
    set_wins = (wr ? wdat : cur) | ev;
  endfunction

  function automatic logic wr_hit(input logic fire, input logic lane0,
                                  input logic [`CIC_ADDR_W-1:0] a,
                                  input logic [`CIC_ADDR_W-1:0] off);
    wr_hit = fire & lane0 & (a == off);
  endfunction

  function automatic logic addr_mapped(input logic [`CIC_ADDR_W-1:0] a);
    addr_mapped = (a == `CIC_OFF_CORE_IRQ_CONTROL) || (a == `CIC_OFF_PERIPH_ENABLES_1) ||
                  (a == `CIC_OFF_PERIPH_ENABLES_2) || (a == `CIC_OFF_PERIPH_FLAGS_1) ||
                  (a == `CIC_OFF_PERIPH_FLAGS_2) || (a == `CIC_OFF_EDGE_CONFIG) ||
                  (a == `CIC_OFF_CORE_STATE);
  endfunction

  cic_pin_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_irq_pin),
    .rising_sel(ext_edge_select_reg),
    .edge_pulse(ext_edge)
  );

  assign is_q1 = (seq_in.q_phase == CIC_Q1);
  assign pin_flag_window = (seq_in.q_phase == CIC_Q4) || is_q1;

  // Source order: t0, pin, portb, periph_1[7:0], periph_2
  assign src_flags = {peripheral_flags_2_reg[0], peripheral_flags_1_reg,
                      core_irq_control_reg[`CIC_BIT_RBIF],
                      core_irq_control_reg[`CIC_BIT_PIN_FLAG],
                      core_irq_control_reg[`CIC_BIT_T0IF]};
  assign src_enables = {peripheral_enables_2_reg[0], peripheral_enables_1_reg,
                        core_irq_control_reg[`CIC_BIT_RBIE],
                        core_irq_control_reg[`CIC_BIT_INTE],
                        core_irq_control_reg[`CIC_BIT_T0IE]};

  assign pending = (|(src_flags[2:0] & src_enables[2:0])) |
                   (core_irq_control_reg[`CIC_BIT_PERIPH_EN] &
                    (|(src_flags[11:3] & src_enables[11:3])));

  // Decision made only at Q1, from the flags sampled at that Q1
  assign take = is_q1 && (state_reg == CIC_ST_RUN) && pending &&
                core_irq_control_reg[`CIC_BIT_GLOBAL_EN] && !sleeping_reg &&
                (wake_hold_reg == 2'd0);

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok = wr_fire && addr_mapped(aw_addr_reg);

  always_comb
  begin
    ctrl_next = set_wins(core_irq_control_reg,
                         wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_CORE_IRQ_CONTROL),
                         w_data_reg,
                         {5'b0_0000, events.t0_overflow,
                          pin_edge_pend_reg & pin_flag_window,
                          events.portb_change});
    pflags1_next = set_wins(peripheral_flags_1_reg,
                            wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_PERIPH_FLAGS_1),
                            w_data_reg, events.periph_1);
    pflags2_next = set_wins(peripheral_flags_2_reg,
                            wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_PERIPH_FLAGS_2),
                            w_data_reg & `CIC_P2_MASK, {7'b000_0000, events.periph_2});
    if (take)
      ctrl_next[`CIC_BIT_GLOBAL_EN] = 1'b0;
    else if (seq_in.return_from_irq)
      ctrl_next[`CIC_BIT_GLOBAL_EN] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_irq_control_reg <= `CIC_RST_BYTE;
      peripheral_enables_1_reg <= `CIC_RST_BYTE;
      peripheral_enables_2_reg <= `CIC_RST_BYTE;
      peripheral_flags_1_reg <= `CIC_RST_BYTE;
      peripheral_flags_2_reg <= `CIC_RST_BYTE;
      ext_edge_select_reg <= 1'b1;
    end
    else
    begin
      core_irq_control_reg <= ctrl_next;
      peripheral_flags_1_reg <= pflags1_next;
      peripheral_flags_2_reg <= pflags2_next;
      if (wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_PERIPH_ENABLES_1))
        peripheral_enables_1_reg <= w_data_reg;
      if (wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_PERIPH_ENABLES_2))
        peripheral_enables_2_reg <= w_data_reg & `CIC_P2_MASK;
      if (wr_hit(wr_ok, w_lane0_reg, aw_addr_reg, `CIC_OFF_EDGE_CONFIG))
        ext_edge_select_reg <= w_data_reg[`CIC_BIT_EDGE_SEL];
    end
  end

  // Edge seen in Q2/Q3 waits for the Q4-Q1 window before the flag sets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_edge_pend_reg <= 1'b0;
    else if (ext_edge)
      pin_edge_pend_reg <= 1'b1;
    else if (pin_flag_window)
      pin_edge_pend_reg <= 1'b0;
  end

  // Fixed-length entry paced by Q1 alone, so instruction length never matters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= CIC_ST_RUN;
    else if (is_q1)
    begin
      unique case (state_reg)
        CIC_ST_RUN: state_reg <= take ? CIC_ST_FLUSH : CIC_ST_RUN;
        CIC_ST_FLUSH: state_reg <= CIC_ST_VECTOR;
        CIC_ST_VECTOR: state_reg <= CIC_ST_RUN;
        default: state_reg <= CIC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending_sampled_reg <= 1'b0;
    else if (is_q1)
      pending_sampled_reg <= pending;
  end

  // Sequencer pulses; only the return address is saved, nothing else
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seq_out <= '0;
    else
    begin
      seq_out.flush <= take;
      seq_out.stack_push <= is_q1 && (state_reg == CIC_ST_FLUSH);
      seq_out.pc_load <= is_q1 && (state_reg == CIC_ST_FLUSH);
      // Full-width vector; the high-bits latch has no path from here
      seq_out.pc_load_value <= `CIC_VECTOR;
      if (is_q1 && (state_reg == CIC_ST_FLUSH))
        seq_out.push_pc <= seq_in.pc;
      seq_out.stack_pop <= seq_in.return_from_irq;
      seq_out.wake <= sleeping_reg && (|(src_flags & src_enables & WAKE_MASK));
    end
  end

  // After wake, skip the next two Q1s so one instruction completes first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleeping_reg <= 1'b0;
      wake_hold_reg <= 2'd0;
    end
    else if (sleeping_reg && (|(src_flags & src_enables & WAKE_MASK)))
    begin
      sleeping_reg <= 1'b0;
      wake_hold_reg <= 2'd2;
    end
    else
    begin
      if (seq_in.sleep_enter)
        sleeping_reg <= 1'b1;
      if (is_q1 && (wake_hold_reg != 2'd0))
        wake_hold_reg <= wake_hold_reg - 2'd1;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CIC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr_reg) ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read: one outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CIC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
      unique case (s_axi_araddr)
        `CIC_OFF_CORE_IRQ_CONTROL: s_axi_rdata <= {24'h00_0000, core_irq_control_reg};
        `CIC_OFF_PERIPH_ENABLES_1: s_axi_rdata <= {24'h00_0000, peripheral_enables_1_reg};
        `CIC_OFF_PERIPH_ENABLES_2: s_axi_rdata <= {24'h00_0000, peripheral_enables_2_reg};
        `CIC_OFF_PERIPH_FLAGS_1: s_axi_rdata <= {24'h00_0000, peripheral_flags_1_reg};
        `CIC_OFF_PERIPH_FLAGS_2: s_axi_rdata <= {24'h00_0000, peripheral_flags_2_reg};
        `CIC_OFF_EDGE_CONFIG: s_axi_rdata <= {31'h0000_0000, ext_edge_select_reg};
        `CIC_OFF_CORE_STATE: s_axi_rdata <= {26'h000_0000, wake_hold_reg, pending_sampled_reg,
                                               sleeping_reg, state_reg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // cic_top

/* File: shared/cic_defines.svh */
// Offsets, field positions, reset values and constants of the core interrupt controller.
// Assumes a 32-bit AXI4-Lite register bus; 8-bit registers sit in the low byte.
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

`define CIC_ADDR_W 8
`define CIC_OFF_CORE_IRQ_CONTROL 8'h00
`define CIC_OFF_PERIPH_ENABLES_1 8'h04
`define CIC_OFF_PERIPH_ENABLES_2 8'h08
`define CIC_OFF_PERIPH_FLAGS_1 8'h0C
`define CIC_OFF_PERIPH_FLAGS_2 8'h10
`define CIC_OFF_EDGE_CONFIG 8'h14
`define CIC_OFF_CORE_STATE 8'h18

`define CIC_BIT_GLOBAL_EN 7
`define CIC_BIT_PERIPH_EN 6
`define CIC_BIT_T0IE 5
`define CIC_BIT_INTE 4
`define CIC_BIT_RBIE 3
`define CIC_BIT_T0IF 2
`define CIC_BIT_PIN_FLAG 1
`define CIC_BIT_RBIF 0
`define CIC_BIT_EDGE_SEL 0
`define CIC_P2_MASK 8'h01

`define CIC_RST_BYTE 8'h00
`define CIC_NUM_SOURCES 12
`define CIC_WAKE_MASK 12'h006
`define CIC_PC_W 13
`define CIC_VECTOR 13'h0004
`define CIC_RESP_OKAY 2'b00
`define CIC_RESP_SLVERR 2'b10

`endif

/* File: shared/cic_pkg.sv */
// Types of the core interrupt controller: phases, sequencer carriers and states.
// Assumes cic_defines.svh is on the include path.
`include "cic_defines.svh"

package cic_pkg;

  typedef enum logic [1:0] {
    CIC_Q1 = 2'b00,
    CIC_Q2 = 2'b01,
    CIC_Q3 = 2'b10,
    CIC_Q4 = 2'b11
  } cic_phase_t;

  typedef enum logic [1:0] {
    CIC_ST_RUN = 2'b00,
    CIC_ST_FLUSH = 2'b01,
    CIC_ST_VECTOR = 2'b11
  } cic_state_t;

  typedef struct packed {
    cic_phase_t q_phase;
    logic sleep_enter;
    logic return_from_irq;
    logic [`CIC_PC_W-1:0] pc;
  } cic_seq_in_t;

  typedef struct packed {
    logic flush;
    logic stack_push;
    logic [`CIC_PC_W-1:0] push_pc;
    logic pc_load;
    logic [`CIC_PC_W-1:0] pc_load_value;
    logic stack_pop;
    logic wake;
  } cic_seq_out_t;

  typedef struct packed {
    logic t0_overflow;
    logic portb_change;
    logic [7:0] periph_1;
    logic periph_2;
  } cic_events_t;

endpackage

/* File: verilog/cic_pin_sync.sv */
// Two-flop synchroniser and edge detector for the external interrupt pin.
// Assumes an asynchronous pin level and a same-clock edge select.
`timescale 1ns/100ps

module cic_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin,
  input wire logic rising_sel,
  output logic edge_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      edge_pulse <= 1'b0;
    end
    else
    begin
      meta_reg <= pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      // Polarity chosen after sync so a select change cannot fake an edge
      edge_pulse <= rising_sel ? (sync_reg & ~last_reg) : (~sync_reg & last_reg);
    end
  end
endmodule // cic_pin_sync

/* File: test/cic_top_asserts.sv */
// Checker for the sequencer and bus outputs of cic_top.
// Assumes binding to cic_top ports; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module cic_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cic_pkg::cic_seq_in_t seq_in,
  input wire cic_pkg::cic_seq_out_t seq_out
);
  import cic_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_idle: assert property ($rose(aresetn) |-> !seq_out.flush && !seq_out.pc_load)
    else $error("sequencer request right after reset");
  chk_vector_addr: assert property (seq_out.pc_load |-> seq_out.pc_load_value == 13'h0004)
    else $error("vector address wrong");
  chk_flush_push: assert property (seq_out.flush |-> ##4 (seq_out.stack_push && seq_out.pc_load))
    else $error("push and vector load not four clocks after flush");
  chk_take_q1: assert property (seq_out.flush |-> $past(seq_in.q_phase) == CIC_Q1)
    else $error("take not at a Q1 edge");
  chk_push_only_pc: assert property (seq_out.stack_push |-> seq_out.pc_load && !seq_out.flush)
    else $error("push without vector load");
  chk_pop_echo: assert property (seq_in.return_from_irq |=> seq_out.stack_pop)
    else $error("return not echoed as pop");
  chk_pop_cause: assert property (seq_out.stack_pop |-> $past(seq_in.return_from_irq))
    else $error("pop without return");
  chk_wake_pulse: assert property (seq_out.wake |=> !seq_out.wake)
    else $error("wake longer than one cycle");
  chk_wake_next_instr: assert property (seq_out.wake |=> !seq_out.pc_load [*8])
    else $error("vector before the instruction after sleep");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // cic_chk

bind cic_top cic_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .seq_in(seq_in),
  .seq_out(seq_out)
);

/* File: test/cic_core_model.sv */
// Behavioural core sequencer: Q phases, program counter, one-deep stack.
// Assumes bench commands arrive as one-cycle pulses on aclk.
`timescale 1ns/100ps

module cic_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_cmd,
  input wire logic ret_cmd,
  input wire cic_pkg::cic_seq_out_t seq_out,
  output cic_pkg::cic_seq_in_t seq_in
);
  import cic_pkg::*;
  logic [12:0] stack_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seq_in <= '0;
      stack_reg <= '0;
    end
    else
    begin
      seq_in.q_phase <= cic_phase_t'(seq_in.q_phase + 2'h1);
      seq_in.sleep_enter <= sleep_cmd;
      seq_in.return_from_irq <= ret_cmd;
      if (seq_out.stack_push)
        stack_reg <= seq_out.push_pc;
      // Flush is only high while the phase is Q2, so its Q4 gate never stalls the count
      if (seq_out.pc_load)
        seq_in.pc <= seq_out.pc_load_value;
      else if (ret_cmd)
        seq_in.pc <= stack_reg;
      else if (seq_in.q_phase == CIC_Q4 && !seq_out.flush)
        seq_in.pc <= seq_in.pc + 13'h0001;
    end
  end
endmodule // cic_core_model

/* File: test/cic_top_test.sv */
// Self-checking bench for cic_top: registers, takes, returns, pin edges, sleep wake.
// Assumes cic_core_model as sequencer and the checker bound to cic_top.
`timescale 1ns/100ps

module cic_top_test;
  import cic_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext_pin, sleep_cmd, ret_cmd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] lfsr;
  cic_events_t events;
  cic_seq_in_t seq_in;
  cic_seq_out_t seq_out;
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  logic [12:0] v_q[$];
  logic [12:0] pc_prev;
  int err_total, tests_run, wake_q, pops;

  cic_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(events), .ext_irq_pin(ext_pin), .seq_in(seq_in), .seq_out(seq_out));
  cic_core_model u_core (.aclk(aclk), .aresetn(aresetn), .sleep_cmd(sleep_cmd),
    .ret_cmd(ret_cmd), .seq_out(seq_out), .seq_in(seq_in));

  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic guard(input int n);
    if (n >= 40)
    begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    logic ad, wd;
    int n;
    ad = 0;
    wd = 0;
    b_q.push_back(e);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 40 && !(ad && wd); n++)
    begin
      @(posedge aclk);
      ad |= awvalid & awready;
      wd |= wvalid & wready;
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
    end
    while (!bvalid && n < 40)
    begin
      @(posedge aclk);
      n++;
    end
    bready <= 0;
    guard(n);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    rd_q.push_back({e, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    n = 0;
    do @(posedge aclk); while (!arready && ++n < 40);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid && ++n < 40);
    rready <= 0;
    guard(n);
  endtask

  task automatic ev(input cic_events_t e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask

  task automatic cmd(input logic s, input logic r);
    @(posedge aclk);
    sleep_cmd <= s;
    ret_cmd <= r;
    @(posedge aclk);
    sleep_cmd <= 0;
    ret_cmd <= 0;
  endtask

  always @(posedge aclk)
  begin
    if (rvalid && rready)
      cmp({rresp, rdata}, rd_q.size() ? rd_q.pop_front() : '1);
    if (bvalid && bready)
      cmp({32'h0, bresp}, b_q.size() ? {32'h0, b_q.pop_front()} : '1);
    if (seq_out.pc_load)
      cmp({21'h0, seq_out.pc_load_value}, v_q.size() ? {21'h0, v_q.pop_front()} : '1);
    if (seq_out.wake)
    begin
      cmp(34'(wake_q), 34'h1);
      wake_q = 0;
    end
    if (seq_out.stack_pop)
      pops++;
    // Saved address must be the PC seen at the pushing edge
    if (seq_out.stack_push)
      cmp({21'h0, seq_out.push_pc}, {21'h0, pc_prev});
    pc_prev = seq_in.pc;
  end

  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard far beyond the longest scenario
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    complete_run();
  end

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, ext_pin, sleep_cmd, ret_cmd} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    events = '0;
    lfsr = 16'h609d;
    aresetn = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 8'h00, 2'h0);
    rd(8'h04, 8'h00, 2'h0);
    rd(8'h14, 8'h01, 2'h0);
    rd(8'h18, 8'h00, 2'h0);
    wr(8'h1c, 8'hff, 2'h2);
    rd(8'h1c, 8'h00, 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nx(lfsr);
      wr(8'h00, lfsr[7:0] & 8'h7f, 2'h0);
      rd(8'h00, lfsr[7:0] & 8'h7f, 2'h0);
    end
    wr(8'h00, 8'h00, 2'h0);
    // Lane 0 strobe low: write ignored but answered OKAY
    wstrb <= 4'he;
    wr(8'h00, 8'h7f, 2'h0);
    wstrb <= 4'hf;
    rd(8'h00, 8'h00, 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      ev({2'b00, 8'(1 << i), 1'b0});
      rd(8'h0c, 8'(1 << i), 2'h0);
      wr(8'h0c, 8'h00, 2'h0);
    end
    ev(11'h400);
    ev(11'h200);
    rd(8'h00, 8'h05, 2'h0);
    ev(11'h001);
    rd(8'h10, 8'h01, 2'h0);
    wr(8'h10, 8'h00, 2'h0);
    wr(8'h04, 8'h01, 2'h0);
    wr(8'h00, 8'h80, 2'h0);
    ev(11'h002);
    repeat (16) @(posedge aclk);
    rd(8'h00, 8'h80, 2'h0);
    v_q.push_back(13'h0004);
    wr(8'h00, 8'hc0, 2'h0);
    repeat (16) @(posedge aclk);
    rd(8'h00, 8'h40, 2'h0);
    wr(8'h0c, 8'h00, 2'h0);
    cmd(0, 1);
    rd(8'h00, 8'hc0, 2'h0);
    wr(8'h00, 8'h10, 2'h0);
    ext_pin <= 1;
    repeat (8) @(posedge aclk);
    rd(8'h00, 8'h12, 2'h0);
    wr(8'h00, 8'h10, 2'h0);
    wr(8'h14, 8'h00, 2'h0);
    ext_pin <= 0;
    repeat (8) @(posedge aclk);
    rd(8'h00, 8'h12, 2'h0);
    wr(8'h00, 8'h10, 2'h0);
    ext_pin <= 1;
    repeat (8) @(posedge aclk);
    rd(8'h00, 8'h10, 2'h0);
    v_q.push_back(13'h0004);
    wr(8'h00, 8'h90, 2'h0);
    ext_pin <= 0;
    repeat (16) @(posedge aclk);
    rd(8'h00, 8'h12, 2'h0);
    wr(8'h00, 8'h48, 2'h0);
    cmd(1, 0);
    rd(8'h18, 8'h04, 2'h0);
    ev(11'h002);
    repeat (8) @(posedge aclk);
    rd(8'h18, 8'h0c, 2'h0);
    wake_q = 1;
    ev(11'h200);
    repeat (8) @(posedge aclk);
    wr(8'h0c, 8'h00, 2'h0);
    wr(8'h00, 8'h08, 2'h0);
    wr(8'h00, 8'h88, 2'h0);
    cmd(1, 0);
    wake_q = 1;
    v_q.push_back(13'h0004);
    ev(11'h200);
    repeat (24) @(posedge aclk);
    rd(8'h00, 8'h09, 2'h0);
    // Mid-run reset must drop every control register enable again
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 8'h00, 2'h0);
    rd(8'h14, 8'h01, 2'h0);
    cmp(34'(v_q.size()), 34'h0);
    cmp(34'(wake_q), 34'h0);
    cmp(34'(pops), 34'h1);
    complete_run();
  end
endmodule // cic_top_test
